//--- logic/dcal_pkg.sv
// package: register layout, reset values and types for the calibration block
package dcal_pkg;
  localparam int NUM_CHAN = 4;
  localparam int CODE_W = 12;
  localparam int OFS_W = 9;
  localparam int GAIN_W = 8;
  localparam int WORD_W = 16;
  // conversion code field in the channel data word
  localparam int CODE_MSB = 15;
  localparam int CODE_LSB = 4;
  // trim field positions
  localparam int OFS_MSB = 8;
  localparam int GAIN_MSB = 7;
  // register select codes of the local access port
  localparam logic [1:0] SEL_OFFSET = 2'h0;
  localparam logic [1:0] SEL_GAIN = 2'h1;
  localparam logic [1:0] SEL_DATA = 2'h2;
  // reset values
  localparam logic [15:0] OFS_RESET = 16'h0000;
  localparam logic [15:0] GAIN_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  // fraction bits of the corrected code: offset step is 1/128 lsb, gain step 1/16 lsb
  localparam int FRAC_W = 7;
  localparam int GAIN_SHIFT = 3;
  localparam int CORR_W = CODE_W + FRAC_W + 3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] sel;
    logic [1:0] chan;
    logic [15:0] wdata;
  } dcal_req_t;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [CORR_W-1:0] value;
  } dcal_out_t;
endpackage

//--- logic/dcal_trim_mem.sv
// small trim store: per-channel offset and gain words with registered read
`timescale 1ns/1ps
`default_nettype none
module dcal_trim_mem
#(
  parameter int CHANS = 4,
  parameter int WIDTH = 9
)
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic wr_in,
  input wire logic [$clog2(CHANS)-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [$clog2(CHANS)-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);
  logic [WIDTH-1:0] mem_q [CHANS];

  ////////////////////////////////////////////////////////////////////////////
  // storage, cleared at reset
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < CHANS; i++)
      begin
        mem_q[i] <= '0;
      end
    end
    else if (wr_in)
    begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered read port
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rdata_out <= '0;
    end
    else
    begin
      rdata_out <= mem_q[raddr_in];
    end
  end
endmodule
`default_nettype wire

//--- logic/dcal_top.sv
// top: user calibration registers and corrected code for four channels
`timescale 1ns/1ps
`default_nettype none
module dcal_top
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire dcal_pkg::dcal_req_t req_in,
  input wire logic bipolar_in,
  input wire logic update_in,
  input wire logic [1:0] update_chan_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  output dcal_pkg::dcal_out_t corr_out
);
  import dcal_pkg::*;

  typedef enum logic [2:0] {
    DCAL_IDLE = 3'b001,
    DCAL_FETCH = 3'b010,
    DCAL_CALC = 3'b100
  } dcal_state_t;

  dcal_state_t state_q;
  logic [1:0] upd_chan_q;
  logic [1:0] rd_sel_q;
  logic [1:0] rd_chan_q;
  logic rd_pend_q;
  logic [OFS_W-1:0] ofs_rd;
  logic [GAIN_W-1:0] gain_rd;
  logic [1:0] mem_raddr;
  logic ofs_wr;
  logic gain_wr;
  logic [WORD_W-1:0] data_q [NUM_CHAN];

  // extract the 12-bit code and extend it to a signed 13-bit value: sign-extended when bipolar, zero-extended otherwise
  function automatic logic signed [CODE_W:0] code_value(input logic [15:0] word,
                                                       input logic bip);
    logic [CODE_W-1:0] c;
    c = word[CODE_MSB:CODE_LSB];
    if (bip)
    begin
      code_value = {c[CODE_W-1], c};
    end
    else
    begin
      code_value = {1'b0, c};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write decode; only the low trim bits are kept
  // upper bits dropped
  assign ofs_wr = req_in.wr && (req_in.sel == SEL_OFFSET);
  assign gain_wr = req_in.wr && (req_in.sel == SEL_GAIN);

  dcal_trim_mem #(.CHANS(NUM_CHAN), .WIDTH(OFS_W)) u_ofs_mem
  (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .wr_in(ofs_wr),
    .waddr_in(req_in.chan),
    .wdata_in(req_in.wdata[OFS_MSB:0]),
    .raddr_in(mem_raddr),
    .rdata_out(ofs_rd)
  );

  dcal_trim_mem #(.CHANS(NUM_CHAN), .WIDTH(GAIN_W)) u_gain_mem
  (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .wr_in(gain_wr),
    .waddr_in(req_in.chan),
    .wdata_in(req_in.wdata[GAIN_MSB:0]),
    .raddr_in(mem_raddr),
    .rdata_out(gain_rd)
  );

  // update fetch has priority over a register read
  assign mem_raddr = (update_in && state_q == DCAL_IDLE) ? update_chan_in : req_in.chan;

  ////////////////////////////////////////////////////////////////////////////
  // channel data words
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        data_q[i] <= DATA_RESET;
      end
    end
    else if (req_in.wr && req_in.sel == SEL_DATA)
    begin
      data_q[req_in.chan] <= {req_in.wdata[CODE_MSB:CODE_LSB], 4'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read, answered two cycles after the request; dropped if an update starts in the same cycle
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rd_pend_q <= 1'b0;
      rd_sel_q <= SEL_OFFSET;
      rd_chan_q <= 2'h0;
    end
    else
    begin
      rd_pend_q <= req_in.rd && !(update_in && state_q == DCAL_IDLE);
      rd_sel_q <= req_in.sel;
      rd_chan_q <= req_in.chan;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rdata_out <= 16'h0000;
      rvalid_out <= 1'b0;
    end
    else
    begin
      rvalid_out <= rd_pend_q;
      if (rd_pend_q)
      begin
        case (rd_sel_q)
          SEL_OFFSET: rdata_out <= {{(WORD_W - OFS_W){1'b0}}, ofs_rd};
          SEL_GAIN: rdata_out <= {{(WORD_W - GAIN_W){1'b0}}, gain_rd};
          SEL_DATA: rdata_out <= data_q[rd_chan_q];
          default: rdata_out <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // update sequencer
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= DCAL_IDLE;
      upd_chan_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        DCAL_IDLE:
        begin
          if (update_in)
          begin
            state_q <= DCAL_FETCH;
            upd_chan_q <= update_chan_in;
          end
        end
        DCAL_FETCH: state_q <= DCAL_CALC;
        DCAL_CALC: state_q <= DCAL_IDLE;
        default: state_q <= DCAL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // corrected code: code*(1 + gain/16 lsb of full scale) + offset/128 lsb
  logic signed [CORR_W-1:0] base_v;
  logic signed [CORR_W-1:0] gain_v;
  logic signed [CORR_W-1:0] ofs_v;
  logic signed [CODE_W:0] code_v;
  // full-width product, so full-scale code times largest gain cannot wrap
  localparam int PROD_W = 2 * CORR_W;
  logic signed [PROD_W-1:0] prod_v;
  logic signed [CORR_W-1:0] gscale_v;
  logic [1:0] fetch_chan_q;
  logic signed [OFS_W-1:0] ofs_hold_q;
  logic signed [GAIN_W-1:0] gain_hold_q;

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ofs_hold_q <= '0;
      gain_hold_q <= '0;
      fetch_chan_q <= 2'h0;
    end
    else if (state_q == DCAL_FETCH)
    begin
      ofs_hold_q <= ofs_rd;
      gain_hold_q <= gain_rd;
      fetch_chan_q <= upd_chan_q;
    end
  end

  always_comb
  begin
    code_v = code_value(data_q[fetch_chan_q], bipolar_in);
    base_v = CORR_W'(code_v) <<< FRAC_W;
    // gain step 1/16 lsb at full scale
    gain_v = CORR_W'(gain_hold_q) <<< GAIN_SHIFT;
    prod_v = PROD_W'(gain_v) * PROD_W'(code_v);
    gscale_v = CORR_W'(prod_v >>> CODE_W);
    ofs_v = CORR_W'(ofs_hold_q);
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      corr_out <= '0;
    end
    else
    begin
      corr_out.valid <= (state_q == DCAL_CALC);
      if (state_q == DCAL_CALC)
      begin
        corr_out.chan <= fetch_chan_q;
        corr_out.value <= base_v + gscale_v + ofs_v;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/dcal_top_assertions.sv
// checker: timing and field relations at the calibration block ports
`timescale 1ns/1ps
`default_nettype none
module dcal_top_assertions
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire dcal_pkg::dcal_req_t req_in,
  input wire logic bipolar_in,
  input wire logic update_in,
  input wire logic [1:0] update_chan_in,
  input wire logic [15:0] rdata_out,
  input wire logic rvalid_out,
  input wire dcal_pkg::dcal_out_t corr_out
);
  import dcal_pkg::*;
  logic [1:0] busy_q;
  logic take;
  assign take = update_in && busy_q == 2'h0;
  ////////////////////////////////////////////////////////////////
  // shadow of the update sequencer
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      busy_q <= 2'h0;
    else if (take)
      busy_q <= 2'h2;
    else if (busy_q != 2'h0)
      busy_q <= busy_q - 2'h1;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_take;
    take;
  endsequence
  sequence s_done;
    ##3 corr_out.valid;
  endsequence
  property p_upd_lat;
    s_take |-> s_done;
  endproperty
  a_upd_lat: assert property (p_upd_lat)
    else $error("update result missing");
  property p_upd_cause;
    corr_out.valid |-> $past(take, 3);
  endproperty
  a_upd_cause: assert property (p_upd_cause)
    else $error("update result without request");
  property p_upd_chan;
    s_take ##3 corr_out.valid |-> corr_out.chan == $past(update_chan_in, 3);
  endproperty
  a_upd_chan: assert property (p_upd_chan)
    else $error("update result on wrong channel");
  property p_upd_gap;
    corr_out.valid |=> !corr_out.valid [*2];
  endproperty
  a_upd_gap: assert property (p_upd_gap)
    else $error("update results too close");
  property p_rd_lat;
    req_in.rd && !take |-> ##2 rvalid_out;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer missing");
  property p_rd_cause;
    rvalid_out |-> $past(req_in.rd, 2);
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("read answer without request");
  property p_ofs_top;
    rvalid_out && $past(req_in.sel, 2) == SEL_OFFSET |-> rdata_out[15:9] == 7'h00;
  endproperty
  a_ofs_top: assert property (p_ofs_top)
    else $error("offset upper bits not zero");
  property p_gain_top;
    rvalid_out && $past(req_in.sel, 2) == SEL_GAIN |-> rdata_out[15:8] == 8'h00;
  endproperty
  a_gain_top: assert property (p_gain_top)
    else $error("gain upper bits not zero");
  property p_code_low;
    rvalid_out && $past(req_in.sel, 2) == SEL_DATA |-> rdata_out[3:0] == 4'h0;
  endproperty
  a_code_low: assert property (p_code_low)
    else $error("code low nibble not zero");
endmodule
bind dcal_top dcal_top_assertions u_chk (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
  .req_in(req_in), .bipolar_in(bipolar_in), .update_in(update_in),
  .update_chan_in(update_chan_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .corr_out(corr_out));
`default_nettype wire

//--- bench/dcal_host_model.sv
// host model: register writes and reads on the local access port
`timescale 1ns/1ps
`default_nettype none
module dcal_host_model
(
  input wire logic mclk_in,
  input wire logic [15:0] rdata_in,
  input wire logic rvalid_in,
  output dcal_pkg::dcal_req_t req_out
);
  import dcal_pkg::*;
  initial req_out = '0;
  function automatic logic [8:0] trim_steps(input int err, input int step);
    return 9'(-err / step);
  endfunction
  task automatic wr(input logic [1:0] sel, input logic [1:0] ch, input logic [15:0] d);
    @(negedge mclk_in);
    req_out = '{wr: 1'b1, rd: 1'b0, sel: sel, chan: ch, wdata: d};
    @(negedge mclk_in);
    req_out = '0;
  endtask
  task automatic rd(input logic [1:0] sel, input logic [1:0] ch, output logic [15:0] d);
    d = 'x;
    @(negedge mclk_in);
    req_out = '{wr: 1'b0, rd: 1'b1, sel: sel, chan: ch, wdata: 16'h0000};
    @(negedge mclk_in);
    req_out = '0;
    for (int n = 0; n < 4 && rvalid_in !== 1'b1; n++)
    begin
      @(posedge mclk_in);
      #1;
    end
    if (rvalid_in === 1'b1)
      d = rdata_in;
  endtask
endmodule
`default_nettype wire

//--- bench/dcal_top_tb_top.sv
// testbench: trim registers and corrected codes of the calibration block
`timescale 1ns/1ps
`default_nettype none
module dcal_top_tb_top;
  import dcal_pkg::*;
  logic mclk_in, rst_b_in, bipolar_in, update_in;
  logic [1:0] update_chan_in;
  dcal_req_t req;
  logic [15:0] rdata;
  logic rvalid;
  dcal_out_t corr;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  dcal_top DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .req_in(req), .bipolar_in(bipolar_in),
    .update_in(update_in), .update_chan_in(update_chan_in), .rdata_out(rdata),
    .rvalid_out(rvalid), .corr_out(corr));
  dcal_host_model host (.mclk_in(mclk_in), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req));
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic conclude;
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      conclude();
    end
  end
  function automatic int expect_val(logic [11:0] cd, logic bip, logic [7:0] g, logic [8:0] o);
    int c;
    c = bip ? int'($signed(cd)) : int'(cd);
    return c * 128 + ((int'($signed(g)) * 8 * c) >>> 12) + int'($signed(o));
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    logic [15:0] d;
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      host.rd(SEL_OFFSET, 2'(c), d);
      chk(d === OFS_RESET, "offset not clear");
      host.rd(SEL_GAIN, 2'(c), d);
      chk(d === GAIN_RESET, "gain not clear");
    end
  endtask
  task automatic t_fields;
    logic [15:0] d;
    host.wr(SEL_OFFSET, 2'h1, 16'hFFFF);
    host.rd(SEL_OFFSET, 2'h1, d);
    chk(d === 16'h01FF, "offset field");
    host.rd(SEL_OFFSET, 2'h0, d);
    chk(d === 16'h0000, "offset leaked");
    host.wr(SEL_GAIN, 2'h2, 16'hFFFF);
    host.rd(SEL_GAIN, 2'h2, d);
    chk(d === 16'h00FF, "gain field");
    host.wr(SEL_DATA, 2'h3, 16'hFFFF);
    host.rd(SEL_DATA, 2'h3, d);
    chk(d === 16'hFFF0, "code field");
  endtask
  task automatic run_upd(input logic [1:0] ch, input logic bip, input int exp_v);
    @(negedge mclk_in);
    update_in = 1'b1;
    update_chan_in = ch;
    bipolar_in = bip;
    @(negedge mclk_in);
    update_in = 1'b0;
    for (int n = 0; n < 6 && corr.valid !== 1'b1; n++)
    begin
      @(posedge mclk_in);
      #1;
    end
    chk(corr.valid === 1'b1 && corr.chan === ch, "update channel");
    chk(corr.value === CORR_W'(exp_v), "corrected code");
  endtask
  task automatic t_corr;
    logic [8:0] ofs [4];
    logic [7:0] gn [4] = '{8'h7F, 8'h80, 8'h01, 8'hFF};
    logic [11:0] cd [4] = '{12'hFFF, 12'h800, 12'h000, 12'h123};
    logic bp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [15:0] d;
    ofs = '{9'h0FF, 9'h100, 9'h000, host.trim_steps(-26, 1)};
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      host.wr(SEL_OFFSET, 2'(c), {7'h00, ofs[c]});
      host.wr(SEL_GAIN, 2'(c), {8'h00, gn[c]});
      host.wr(SEL_DATA, 2'(c), {cd[c], 4'h0});
    end
    for (int c = 0; c < NUM_CHAN; c++)
      run_upd(2'(c), bp[c], expect_val(cd[c], bp[c], gn[c], ofs[c]));
    host.wr(SEL_OFFSET, 2'h0, {7'h00, host.trim_steps(26, 1)});
    run_upd(2'h0, 1'b0, expect_val(cd[0], 1'b0, gn[0], 9'h1E6));
    fork
      run_upd(2'h2, 1'b0, expect_val(cd[2], 1'b0, gn[2], ofs[2]));
      begin
        @(negedge mclk_in);
        host.rd(SEL_DATA, 2'h3, d);
        chk(d === {cd[3], 4'h0}, "code read during update");
      end
    join
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b_in = 1'b0;
    bipolar_in = 1'b0;
    update_in = 1'b0;
    update_chan_in = 2'h0;
    repeat (12) @(negedge mclk_in);
    rst_b_in = 1'b1;
    t_reset_vals();
    t_fields();
    t_corr();
    conclude();
  end
endmodule
`default_nettype wire
